// ===== include/sdf_pkg.sv
package sdf_pkg;
	// Device register offsets on the link
	localparam logic [7:0] REG_HOST_IF_CTRL = 8'h06;
	localparam logic [7:0] REG_HOST_INT_CTRL = 8'h07;
	localparam logic [7:0] REG_INT_STATUS = 8'h2d;
	localparam logic [7:0] REG_FIFO_FORMAT = 8'h08;
	// Field positions
	localparam int HIC_ASYNC_BIT = 7;
	localparam int HINTC_MASK_SYNC_BIT = 2;
	localparam int HINTC_MASK_ASYNC_BIT = 3;
	localparam int IST_SYNC_BIT = 5;
	localparam int IST_ASYNC_BIT = 6;
	localparam int FMT_NO_TS_BIT = 0;
	// Values after reset
	localparam logic [7:0] HIC_RESET = 8'h00;
	localparam logic [7:0] HINTC_RESET = 8'h00;
	localparam logic [7:0] FMT_RESET = 8'h00;
	// Output channel numbers on the link
	localparam logic [1:0] CH_NON_WAKE = 2'h1;
	localparam logic [1:0] CH_WAKE = 2'h2;
	localparam logic [1:0] CH_STATUS = 2'h3;
	// Event identifiers, non-wake-up and wake-up
	localparam logic [7:0] ID_TEMP_NW = 8'h80;
	localparam logic [7:0] ID_TEMP_WK = 8'h84;
	localparam logic [7:0] ID_SDELTA_NW = 8'hfb;
	localparam logic [7:0] ID_SDELTA_WK = 8'hf5;
	localparam logic [7:0] ID_FULL_TS_NW = 8'hfd;
	localparam logic [7:0] ID_FULL_TS_WK = 8'hf7;
	localparam logic [7:0] ID_META_NW = 8'hfe;
	localparam logic [7:0] ID_META_WK = 8'hf8;
	localparam logic [7:0] ID_FILLER = 8'hff;
	localparam logic [7:0] ID_PADDING = 8'h00;
	localparam logic [7:0] META_SPACER = 8'h00;
	// Frame layout counts in bytes
	localparam logic [5:0] DESC_BYTES = 6'h04;
	localparam logic [5:0] META_BYTES = 6'h04;
	localparam logic [5:0] FULL_TS_BYTES = 6'h06;
	localparam logic [3:0] TEMP_EVT_BYTES = 4'h3;
	// Controller register offsets on APB
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_IRQ_STATUS = 8'h08;
	localparam logic [7:0] APB_IRQ_MASK = 8'h0c;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_DEV_BIT = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	typedef enum logic [1:0] {OP_NONE = 2'h0, OP_WR = 2'h1, OP_RD = 2'h2, OP_CH = 2'h3} sdf_op_t;
	typedef enum logic [1:0] {HST_IDLE = 2'h0, HST_ISSUE = 2'h1, HST_CAPT = 2'h3} sdf_hst_t;
endpackage

// ===== include/sdf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdf_link_if;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [1:0] ch_sel;
	logic ch_rd;
	logic [7:0] ch_data;
	logic ch_valid;
	logic host_irq;
	modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd, ch_sel, ch_rd,
		output reg_rdata, ch_data, ch_valid, host_irq);
	modport host (output reg_addr, reg_wdata, reg_wr, reg_rd, ch_sel, ch_rd,
		input reg_rdata, ch_data, ch_valid, host_irq);
endinterface
`default_nettype wire

// ===== hdl/sdf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_framer import sdf_pkg::*; #(
	parameter int MAX_PAY = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Frame request
	input wire logic start,
	input wire logic wake,
	input wire logic ts_en,
	input wire logic [39:0] tstamp,
	input wire logic [8*MAX_PAY-1:0] payload,
	input wire logic [3:0] pay_len,
	// Byte stream
	input wire logic take,
	output logic busy,
	output logic [7:0] byte_out
);
	if (MAX_PAY < 1 || MAX_PAY > 8) begin : g_chk
		$error("MAX_PAY must be 1 to 8");
	end

	typedef struct packed {
		logic busy;
		logic [4:0] idx;
		logic wake;
		logic ts_en;
		logic [39:0] ts;
		logic [8*MAX_PAY-1:0] pay;
		logic [3:0] len;
		logic [15:0] bcnt;
	} sdf_frm_t;

	sdf_frm_t s, next_s;
	logic [5:0] blen, total, hdr, pos, k;

	// Geometry of the single block of this transfer
	always_comb begin
		blen = META_BYTES + (s.ts_en ? FULL_TS_BYTES : 6'h00) + {2'h0, s.len};
		total = ((blen + 6'h03) & 6'h3c) + DESC_BYTES; // Last block ends on a 32-bit boundary
		hdr = DESC_BYTES + blen - {2'h0, s.len};
		pos = {1'b0, s.idx};
		k = pos - hdr;
	end

	// Byte at the current position; every multi-byte field goes low byte first
	always_comb begin
		byte_out = ID_PADDING; // Pad after the payload
		if (pos == 6'h00) begin
			byte_out = {2'h0, total - 6'h02}; // Length counts from the small delta on
		end else if (pos == 6'h01) begin
			byte_out = 8'h00;
		end else if (pos == 6'h02) begin
			byte_out = s.wake ? ID_SDELTA_WK : ID_SDELTA_NW;
		end else if (pos == 6'h03) begin
			byte_out = 8'h00;
		end else if (pos == 6'h04) begin
			byte_out = s.wake ? ID_META_WK : ID_META_NW;
		end else if (pos == 6'h05) begin
			byte_out = META_SPACER;
		end else if (pos == 6'h06) begin
			byte_out = s.bcnt[7:0];
		end else if (pos == 6'h07) begin
			byte_out = s.bcnt[15:8];
		end else if (s.ts_en && pos == 6'h08) begin
			byte_out = s.wake ? ID_FULL_TS_WK : ID_FULL_TS_NW; // Omitted when suppressed
		end else if (s.ts_en && pos < 6'h0e) begin
			byte_out = s.ts[(pos - 6'h09) * 8 +: 8];
		end else if (pos < hdr + {2'h0, s.len}) begin
			byte_out = s.pay[k * 8 +: 8];
		end
	end

	assign busy = s.busy;

	// Load on start, step on take, close on the last byte
	always_comb begin
		next_s = s;
		if (s.busy && take) begin
			next_s.idx = s.idx + 5'h01;
			if (pos == total - 6'h01) begin
				next_s.busy = 1'b0;
				next_s.bcnt = s.bcnt + 16'h0001;
			end
		end else if (!s.busy && start) begin
			next_s.busy = 1'b1;
			next_s.idx = 5'h00;
			next_s.wake = wake;
			next_s.ts_en = ts_en;
			next_s.ts = tstamp;
			next_s.pay = payload;
			next_s.len = pay_len;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/sdf_device.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Multi-byte fields go out low byte first
// - Timestamp suppressed: block starts with meta only
// - Host suppresses timestamps only without overflow risk
// - Sensor channels always use descriptor-plus-block framing
// - Async select bit picks status channel mode
// - Status bit 5: sync response available
// - Status bit 6: async data available
// - Control bit 2 masks sync interrupt
// - Control bit 3 masks async interrupt
// - Host selects sync mode before commands; sdf_host leaves the mode switch order to software
// - Sync mode holds async messages in buffer
// - Host returns to async after response read; sdf_host leaves the mode switch order to software
// - Sync mode sends bare command responses only
// - Async mode delivers buffer, raises interrupt
// - Async mode frames errors, debug, responses
// - Host scans async stream for its response; sdf_host only returns each byte, software parses the stream
// - Temperature: IDs 128/132, three bytes, signed
// - Pad last block to four bytes
module sdf_device import sdf_pkg::*; #(
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Host link
	sdf_link_if.dev lnk,
	// Temperature samples
	input wire logic temp_valid,
	input wire logic temp_wake,
	input wire logic [15:0] temp_value,
	output logic temp_ready,
	// Command responses
	input wire logic resp_valid,
	input wire logic [63:0] resp_data,
	input wire logic [3:0] resp_len,
	// Error and debug messages
	input wire logic evt_valid,
	input wire logic [63:0] evt_data,
	input wire logic [3:0] evt_len,
	output logic evt_ready,
	// Mode seen by the firmware side
	output logic async_mode
);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("DEPTH must be a power of two, at least 2");
	end

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [7:0] hic;
		logic [7:0] hintc;
		logic [7:0] fmt;
		logic [7:0] rdata;
		logic [7:0] ch_data;
		logic ch_valid;
		logic [1:0] tpend;
		logic [1:0][15:0] tval;
		logic rsp_pend;
		logic [63:0] rsp_data;
		logic [3:0] rsp_len;
		logic [3:0] rsp_idx;
		logic [DEPTH-1:0][67:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [39:0] tsc;
	} sdf_dev_t;

	sdf_dev_t s, next_s;
	logic [2:0] f_start, f_take, f_busy;
	logic [2:0][63:0] f_pay;
	logic [2:0][3:0] f_len;
	logic [2:0][7:0] f_byte;
	logic [7:0] istat;
	logic sync_avail, async_avail;

	assign async_mode = s.hic[HIC_ASYNC_BIT];
	assign temp_ready = ~s.tpend[temp_wake];
	// A response in async mode takes the buffer port this cycle
	assign evt_ready = (s.cnt != FULL_CNT) && !(resp_valid && async_mode);

	// Status levels follow what is waiting to be read
	assign sync_avail = s.rsp_pend && !async_mode;
	assign async_avail = async_mode && (s.cnt != '0 || f_busy[2]);
	always_comb begin
		istat = 8'h00;
		istat[IST_SYNC_BIT] = sync_avail;
		istat[IST_ASYNC_BIT] = async_avail;
	end
	// Masks only gate the pin; the status register still shows the event
	assign lnk.host_irq = (istat[IST_SYNC_BIT] && !s.hintc[HINTC_MASK_SYNC_BIT])
		|| (istat[IST_ASYNC_BIT] && !s.hintc[HINTC_MASK_ASYNC_BIT]);
	assign lnk.reg_rdata = s.rdata;
	assign lnk.ch_data = s.ch_data;
	assign lnk.ch_valid = s.ch_valid;

	// Framers: non-wake, wake, and status channel in async mode
	for (genvar g = 0; g < 3; g++) begin : g_frm
		sdf_framer #(.MAX_PAY(8)) u_frm (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.start(f_start[g]),
			.wake(g == 1),
			.ts_en(~s.fmt[FMT_NO_TS_BIT]),
			.tstamp(s.tsc),
			.payload(f_pay[g]),
			.pay_len(f_len[g]),
			.take(f_take[g]),
			.busy(f_busy[g]),
			.byte_out(f_byte[g])
		);
	end

	// Next state of the whole device end
	always_comb begin
		logic push;
		logic pop;
		logic [67:0] entry;
		push = 1'b0;
		pop = 1'b0;
		entry = '0;
		next_s = s;
		f_start = '0;
		f_take = '0;
		// Temperature event: id then value low byte first
		f_pay[0] = {40'h0, s.tval[0], ID_TEMP_NW};
		f_pay[1] = {40'h0, s.tval[1], ID_TEMP_WK};
		f_len[0] = TEMP_EVT_BYTES;
		f_len[1] = TEMP_EVT_BYTES;
		f_pay[2] = s.mem[s.rp][63:0];
		f_len[2] = s.mem[s.rp][67:64];
		next_s.tsc = s.tsc + 40'h1;
		next_s.ch_valid = 1'b0;

		// Sensor channels always leave through a framer
		for (int i = 0; i < 2; i++) begin
			if (s.tpend[i] && !f_busy[i]) begin
				f_start[i] = 1'b1;
				next_s.tpend[i] = 1'b0;
			end
		end
		// A new sample wins over the start that empties the slot
		if (temp_valid) begin
			next_s.tpend[temp_wake] = 1'b1;
			next_s.tval[temp_wake] = temp_value;
		end

		// Buffered messages are only framed out in async mode
		if (async_mode && s.cnt != '0 && !f_busy[2]) begin
			pop = 1'b1;
			f_start[2] = 1'b1;
		end

		// Link register access
		if (lnk.reg_wr) begin
			case (lnk.reg_addr)
				REG_HOST_IF_CTRL: next_s.hic = lnk.reg_wdata;
				REG_HOST_INT_CTRL: next_s.hintc = lnk.reg_wdata;
				REG_FIFO_FORMAT: next_s.fmt = lnk.reg_wdata;
				default: ;
			endcase
		end
		if (lnk.reg_rd) begin
			case (lnk.reg_addr)
				REG_HOST_IF_CTRL: next_s.rdata = s.hic;
				REG_HOST_INT_CTRL: next_s.rdata = s.hintc;
				REG_FIFO_FORMAT: next_s.rdata = s.fmt;
				REG_INT_STATUS: next_s.rdata = istat;
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Channel byte read; an empty channel answers with valid low
		if (lnk.ch_rd) begin
			next_s.ch_data = 8'h00;
			case (lnk.ch_sel)
				CH_NON_WAKE, CH_WAKE: begin
					if (f_busy[lnk.ch_sel - 2'h1]) begin
						f_take[lnk.ch_sel - 2'h1] = 1'b1;
						next_s.ch_valid = 1'b1;
						next_s.ch_data = f_byte[lnk.ch_sel - 2'h1];
					end
				end
				CH_STATUS: begin
					if (async_mode && f_busy[2]) begin
						f_take[2] = 1'b1;
						next_s.ch_valid = 1'b1;
						next_s.ch_data = f_byte[2];
					end else if (!async_mode && s.rsp_pend) begin
						next_s.ch_valid = 1'b1; // Bare response bytes, low first
						next_s.ch_data = s.rsp_data[s.rsp_idx * 8 +: 8];
						next_s.rsp_idx = s.rsp_idx + 4'h1;
						if (s.rsp_idx == s.rsp_len - 4'h1) begin
							next_s.rsp_pend = 1'b0;
						end
					end
				end
				default: ;
			endcase
		end

		// Responses: direct in sync mode, into the stream in async mode
		if (resp_valid && async_mode) begin
			push = 1'b1;
			entry = {resp_len, resp_data};
		end else if (resp_valid) begin
			next_s.rsp_pend = 1'b1;
			next_s.rsp_data = resp_data;
			next_s.rsp_len = resp_len;
			next_s.rsp_idx = 4'h0;
		end else if (evt_valid && evt_ready) begin
			push = 1'b1; // Held until async mode
			entry = {evt_len, evt_data};
		end
		// A full buffer drops the message; evt_ready warns the source
		if (push && s.cnt == FULL_CNT) begin
			push = 1'b0;
		end
		if (push) begin
			next_s.mem[s.wp] = entry;
			next_s.wp = s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.hic <= HIC_RESET;
			s.hintc <= HINTC_RESET;
			s.fmt <= FMT_RESET;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/sdf_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_host import sdf_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt to software
	output logic irq,
	// Device link
	sdf_link_if.host lnk
);
	typedef struct packed {
		sdf_hst_t st;
		sdf_op_t op;
		logic [1:0] chan;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic rvalid;
		logic [31:0] prdata;
		logic pslverr;
		logic [1:0] istat;
		logic [1:0] imask;
		logic [2:0] sync;
		logic dev_irq;
	} sdf_hst_state_t;

	sdf_hst_state_t s, next_s;

	// Strobes last the one issue cycle
	assign lnk.reg_addr = s.addr;
	assign lnk.reg_wdata = s.wdata;
	assign lnk.ch_sel = s.chan;
	assign lnk.reg_wr = (s.st == HST_ISSUE) && (s.op == OP_WR);
	assign lnk.reg_rd = (s.st == HST_ISSUE) && (s.op == OP_RD);
	assign lnk.ch_rd = (s.st == HST_ISSUE) && (s.op == OP_CH);
	assign prdata = s.prdata;
	assign pready = 1'b1; // Zero wait states
	assign pslverr = s.pslverr;
	assign irq = |(s.istat & ~s.imask);

	always_comb begin
		logic setup;
		logic wr;
		logic [1:0] set;
		setup = psel && !penable;
		wr = psel && penable && pwrite;
		set = 2'h0;
		next_s = s;

		// Pin input: three flops, a change counts once the last two agree
		next_s.sync = {s.sync[1:0], lnk.host_irq};
		if (s.sync[2] == s.sync[1]) begin
			next_s.dev_irq = s.sync[2];
		end
		set[IRQ_DEV_BIT] = next_s.dev_irq && !s.dev_irq;

		// Link sequencer; the device answers one edge after the strobe
		case (s.st)
			HST_IDLE: begin
				if (wr && paddr == APB_CMD && pwdata[1:0] != OP_NONE) begin
					// Mode switching order is left to software
					next_s.st = HST_ISSUE;
					next_s.op = sdf_op_t'(pwdata[1:0]);
					next_s.chan = pwdata[3:2];
					next_s.addr = pwdata[15:8];
					next_s.wdata = pwdata[23:16];
					next_s.rvalid = 1'b0;
				end
			end
			HST_ISSUE: next_s.st = HST_CAPT;
			HST_CAPT: begin
				next_s.st = HST_IDLE;
				set[IRQ_DONE_BIT] = 1'b1;
				if (s.op == OP_RD) begin
					next_s.rdata = lnk.reg_rdata;
					next_s.rvalid = 1'b1;
				end else if (s.op == OP_CH) begin
					// Stream is parsed by software
					next_s.rdata = lnk.ch_data;
					next_s.rvalid = lnk.ch_valid;
				end
			end
			default: next_s.st = HST_IDLE;
		endcase

		// Register writes; a set in the same cycle beats the clear
		if (wr && paddr == APB_IRQ_STATUS) begin
			next_s.istat = s.istat & ~pwdata[1:0];
		end
		if (wr && paddr == APB_IRQ_MASK) begin
			next_s.imask = pwdata[1:0];
		end
		next_s.istat = next_s.istat | set;

		// Read data and error are prepared in the setup cycle
		if (setup) begin
			next_s.pslverr = 1'b0;
			case (paddr)
				APB_CMD: next_s.prdata = {24'h0, s.addr};
				APB_STATUS: next_s.prdata = {16'h0, s.rdata, 5'h0, s.rvalid, s.dev_irq, s.st != HST_IDLE};
				APB_IRQ_STATUS: next_s.prdata = {30'h0, s.istat};
				APB_IRQ_MASK: next_s.prdata = {30'h0, s.imask};
				default: begin
					next_s.prdata = 32'h0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= HST_IDLE;
			s.imask <= IRQ_MASK_RESET;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== verification/sdf_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sdf_link_sva import sdf_pkg::*; (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register access
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Channel reads and interrupt
	input wire logic [1:0] ch_sel,
	input wire logic ch_rd,
	input wire logic [7:0] ch_data,
	input wire logic ch_valid,
	input wire logic host_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic async_sh, msk_sync, msk_async, st_rd;
	// Status read strobe
	assign st_rd = reg_rd && reg_addr == REG_INT_STATUS;
	// Shadow of mode and masks, fed by the same strobe the device sees
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			async_sh <= HIC_RESET[HIC_ASYNC_BIT];
			msk_sync <= HINTC_RESET[HINTC_MASK_SYNC_BIT];
			msk_async <= HINTC_RESET[HINTC_MASK_ASYNC_BIT];
		end else if (reg_wr && reg_addr == REG_HOST_IF_CTRL) begin
			async_sh <= reg_wdata[HIC_ASYNC_BIT];
		end else if (reg_wr && reg_addr == REG_HOST_INT_CTRL) begin
			msk_sync <= reg_wdata[HINTC_MASK_SYNC_BIT];
			msk_async <= reg_wdata[HINTC_MASK_ASYNC_BIT];
		end
	end
	a_valid_after_rd: assert property (ch_valid |-> $past(ch_rd))
		else $error("channel byte without a read strobe");
	a_data_holds: assert property (!$past(ch_rd) |-> $stable(ch_data))
		else $error("channel data moved without a read");
	a_empty_zero: assert property (ch_rd ##1 !ch_valid |-> ch_data == 8'h00)
		else $error("empty channel read gave nonzero data");
	a_status_no_async: assert property (st_rd && !async_sh |=> !reg_rdata[IST_ASYNC_BIT])
		else $error("async status bit set in sync mode");
	a_status_no_sync: assert property (st_rd && async_sh |=> !reg_rdata[IST_SYNC_BIT])
		else $error("sync status bit set in async mode");
	a_sync_mask: assert property (!async_sh && msk_sync |-> !host_irq)
		else $error("masked sync interrupt raised");
	a_async_mask: assert property (async_sh && msk_async |-> !host_irq)
		else $error("masked async interrupt raised");
	// Only judged when no other status bit can drive the pin
	a_irq_follows: assert property (st_rd ##1 (reg_rdata & 8'h9f) == 8'h00 |->
		$past(host_irq) == |(reg_rdata[6:5] & ~{$past(msk_async), $past(msk_sync)}))
		else $error("interrupt pin disagrees with status and mask");
	a_mode_readback: assert property (reg_rd && reg_addr == REG_HOST_IF_CTRL |=>
		reg_rdata[HIC_ASYNC_BIT] == async_sh)
		else $error("mode bit readback wrong");
	cover property (ch_valid && ch_data == ID_TEMP_NW);
	cover property (ch_rd && ch_sel == CH_STATUS ##1 ch_valid);
	cover property (async_sh && host_irq);
	cover property (!async_sh && host_irq);
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import sdf_pkg::*; ();
	logic ref_clk = 1'b0, rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, irq, rerr, temp_ready, evt_ready, async_mode;
	logic temp_valid = 1'b0, temp_wake = 1'b0, resp_valid = 1'b0, evt_valid = 1'b0;
	logic [15:0] temp_value = 16'h0000;
	logic [63:0] resp_data = 64'h0, evt_data = 64'h0;
	logic [3:0] resp_len = 4'h1, evt_len = 4'h1;
	logic [7:0] ch_last = 8'h00;
	int ch_count = 0, miscompares = 0, tests_run = 0;
	sdf_link_if link();
	sdf_device sdf_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(link), .temp_valid(temp_valid),
		.temp_wake(temp_wake), .temp_value(temp_value), .temp_ready(temp_ready), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_len(resp_len), .evt_valid(evt_valid), .evt_data(evt_data),
		.evt_len(evt_len), .evt_ready(evt_ready), .async_mode(async_mode));
	sdf_host sdf_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.lnk(link));
	sdf_link_sva sdf_link_sva_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
		.ch_sel(link.ch_sel), .ch_rd(link.ch_rd), .ch_data(link.ch_data), .ch_valid(link.ch_valid),
		.host_irq(link.host_irq));
	// 10 MHz clock
	always #50 ref_clk = ~ref_clk;
	// Record every byte the device hands over on the wire
	always @(posedge ref_clk) begin
		if (link.ch_valid === 1'b1) begin
			ch_last <= link.ch_data;
			ch_count <= ch_count + 1;
		end
	end
	task automatic summarize();
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; pready is sampled, never assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Issue a link command and poll until the sequencer is idle
	task automatic cmd(input logic [1:0] op, input logic [1:0] ch, input logic [7:0] a, input logic [7:0] d);
		int k;
		apb(1'b1, APB_CMD, {8'h00, d, a, 4'h0, ch, op});
		k = 0;
		do begin
			apb(1'b0, APB_STATUS, 32'h0);
			k++;
		end while (rdat[0] !== 1'b0 && k < 20);
		if (k == 20)
			miscompares++;
	endtask
	task automatic rd_none(input logic [1:0] ch);
		int n;
		n = ch_count;
		cmd(OP_CH, ch, 8'h00, 8'h00);
		chk(32'(ch_count - n), 32'h0);
	endtask
	// Read a whole frame byte by byte; indices lo..hi are not predictable
	task automatic rd_chan(input logic [1:0] ch, input logic [7:0] e[$], input int lo, input int hi);
		int n;
		foreach (e[i]) begin
			n = ch_count;
			cmd(OP_CH, ch, 8'h00, 8'h00);
			chk(32'(ch_count - n), 32'h1);
			if (i < lo || i > hi)
				chk({24'h0, ch_last}, {24'h0, e[i]});
		end
		rd_none(ch);
	endtask
	task automatic temp(input logic w, input logic [15:0] v);
		@(posedge ref_clk);
		temp_valid <= 1'b1;
		temp_wake <= w;
		temp_value <= v;
		@(posedge ref_clk);
		temp_valid <= 1'b0;
		// The slot stays taken for one cycle until its framer starts
		@(posedge ref_clk);
		chk(32'(temp_ready), 32'h0);
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic t_regs();
		apb(1'b0, APB_IRQ_MASK, 32'h0);
		chk(32'(rerr), 32'h0);
		chk(rdat, {30'h0, IRQ_MASK_RESET});
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(rerr), 32'h1);
		chk(rdat, 32'h0);
		cmd(OP_RD, 2'h0, REG_HOST_IF_CTRL, 8'h00);
		chk(32'(rdat[15:8]), 32'(HIC_RESET));
		cmd(OP_RD, 2'h0, REG_HOST_INT_CTRL, 8'h00);
		chk(32'(rdat[15:8]), 32'(HINTC_RESET));
		chk(32'(async_mode), 32'h0);
		cmd(OP_WR, 2'h0, REG_INT_STATUS, 8'hff);
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[15:8]), 32'h0);
	endtask
	// Wake frame with timestamp, then non-wake frame without, negative value
	task automatic t_frames();
		temp(1'b1, 16'h1234);
		rd_chan(CH_WAKE, '{8'h12, 8'h00, 8'hf5, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00, 8'hf7, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h84, 8'h34, 8'h12, 8'h00, 8'h00, 8'h00}, 9, 13);
		// Nothing can overflow here, so dropping the timestamp is safe
		cmd(OP_WR, 2'h0, REG_FIFO_FORMAT, 8'h01);
		temp(1'b0, 16'hf63c);
		rd_chan(CH_NON_WAKE, '{8'h0a, 8'h00, 8'hfb, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00,
			8'h80, 8'h3c, 8'hf6, 8'h00}, 99, 0);
	endtask
	// Response arrives while the host keeps sync mode for its command
	task automatic t_sync();
		@(posedge ref_clk);
		resp_data <= 64'h0000_0000_00c2_b1a0;
		resp_len <= 4'h3;
		resp_valid <= 1'b1;
		@(posedge ref_clk);
		resp_valid <= 1'b0;
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[8 + IST_SYNC_BIT]), 32'h1);
		chk(32'(link.host_irq), 32'h1);
		cmd(OP_WR, 2'h0, REG_HOST_INT_CTRL, 8'h04);
		chk(32'(link.host_irq), 32'h0);
		cmd(OP_WR, 2'h0, REG_HOST_INT_CTRL, 8'h00);
		rd_chan(CH_STATUS, '{8'ha0, 8'hb1, 8'hc2}, 99, 0);
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[8 + IST_SYNC_BIT]), 32'h0);
	endtask
	// Debug message held in sync mode, released as a frame in async mode
	task automatic t_async();
		@(posedge ref_clk);
		evt_data <= 64'h0000_0000_0000_beef;
		evt_len <= 4'h2;
		evt_valid <= 1'b1;
		do @(posedge ref_clk); while (evt_ready !== 1'b1);
		evt_valid <= 1'b0;
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[8 + IST_ASYNC_BIT]), 32'h0);
		rd_none(CH_STATUS);
		cmd(OP_WR, 2'h0, REG_HOST_IF_CTRL, 8'h80);
		chk(32'(async_mode), 32'h1);
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[8 + IST_ASYNC_BIT]), 32'h1);
		chk(32'(link.host_irq), 32'h1);
		cmd(OP_WR, 2'h0, REG_HOST_INT_CTRL, 8'h08);
		chk(32'(link.host_irq), 32'h0);
		cmd(OP_WR, 2'h0, REG_HOST_INT_CTRL, 8'h00);
		// Host walks the framed stream to find its data
		rd_chan(CH_STATUS, '{8'h0a, 8'h00, 8'hfb, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00,
			8'hef, 8'hbe, 8'h00, 8'h00}, 99, 0);
		cmd(OP_RD, 2'h0, REG_INT_STATUS, 8'h00);
		chk(32'(rdat[8 + IST_ASYNC_BIT]), 32'h0);
	endtask
	// Sticky controller events, mask blocks, write one clears
	task automatic t_ctrl();
		apb(1'b0, APB_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h3);
		chk(32'(irq), 32'h1);
		apb(1'b1, APB_IRQ_MASK, 32'h3);
		// A write lands at the access edge; look once it has settled
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
		apb(1'b1, APB_IRQ_STATUS, 32'h3);
		apb(1'b0, APB_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b1, APB_IRQ_MASK, 32'h0);
		@(negedge ref_clk);
		chk(32'(irq), 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_frames();
		t_sync();
		t_async();
		t_ctrl();
		summarize();
	end
	// Whole run needs under a thousand cycles; a hang ends here
	initial begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire
